// *** cossd_pkg.sv ***
// Constants and types for the clock output shape, enable and stop block
package cossd_pkg;

    // ****************************************************************
    // Register port geometry
    // ****************************************************************
    localparam int ADDR_W  = 8;               // Byte address width
    localparam int DATA_W  = 8;               // Byte data width
    localparam int RATIO_W = 24;              // Divider configuration width
    localparam int PER_W   = 16;              // Frame period field width
    localparam int DIFF_N  = 8;               // Differential outputs
    localparam int SE_N    = 4;               // Single-ended outputs
    localparam int HALT_N  = 2;               // Stoppable outputs

    // ****************************************************************
    // Register offsets (multi-byte: lowest address holds top byte)
    // ****************************************************************
    localparam logic [7:0] ADDR_S1D_HI  = 8'h95; // Bits 23:16
    localparam logic [7:0] ADDR_S1D_MID = 8'h96; // Bits 15:8
    localparam logic [7:0] ADDR_S1D_LO  = 8'h97; // Bits 7:0
    localparam logic [7:0] ADDR_DIFF_EN = 8'hB0;
    localparam logic [7:0] ADDR_SE_EN   = 8'hB1;
    localparam logic [7:0] ADDR_STOP    = 8'hB8;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [23:0] RST_S1D     = 24'h00_0032;
    localparam logic [7:0]  RST_DIFF_EN = 8'h00;
    localparam logic [7:0]  RST_SE_EN   = 8'h00;
    localparam logic [7:0]  RST_STOP    = 8'h00;
    localparam logic [7:0]  RD_ZERO     = 8'h00;

    // ****************************************************************
    // Divider configuration fields
    // ****************************************************************
    localparam int         MODE_HI    = 23;    // Shape select field top
    localparam int         MODE_LO    = 20;    // Shape select field bottom
    localparam logic [3:0] MODE_FRAME = 4'hF;  // Frame-pulse shape code
    localparam int         SEL_HI     = 17;    // Related clock select top
    localparam int         SEL_LO     = 16;    // Related clock select bottom
    localparam int         POL_BIT    = 18;    // 1 = inverted pulse
    localparam int         TYPE_BIT   = 19;    // 1 = edge-marked pulse
    localparam logic [1:0] SEL_A      = 2'h0;
    localparam logic [1:0] SEL_B      = 2'h1;
    localparam logic [1:0] SEL_C      = 2'h2;
    localparam logic [23:0] RATIO_MAX = 24'hEF_FFFF; // Largest plain ratio

    // ****************************************************************
    // Stop control fields and codes
    // ****************************************************************
    localparam int         STOP_C_LO  = 0;     // Synth 0 divider C field
    localparam int         STOP_D_LO  = 2;     // Synth 0 divider D field
    localparam logic [1:0] STOP_LOW   = 2'h2;  // Park low after fall
    localparam logic [1:0] STOP_HIGH  = 2'h3;  // Park high after rise

    // Per-output halt sequencing
    typedef enum logic [1:0] {HALT_RUN, HALT_PARKED} cossd_halt_type;

endpackage

// *** cossd_divider.sv ***
// Counter that divides the system clock into a near 50% duty clock
`timescale 1ns/1ps
module cossd_divider #(
    parameter int WIDTH = 24
) (
    input  wire logic             clk_sys,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] ratio,
    output logic                  level,
    output logic                  rise,
    output logic                  fall
);

    // ****************************************************************
    // State
    // ****************************************************************
    logic [WIDTH-1:0] cnt_reg;             // Position within one period
    logic [WIDTH-1:0] cnt_next;
    logic             level_next;
    logic [WIDTH-1:0] eff;                 // Ratio clamped to at least 2
    localparam logic [WIDTH-1:0] TWO = WIDTH'(2);
    localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

    // Next count and level; a ratio change takes hold at once for the
    // current period, and the count wraps next if already past the new end
    always_comb
    begin
        eff = (ratio < TWO) ? TWO : ratio;
        if (cnt_reg >= eff - ONE)
        begin
            cnt_next = '0;
        end
        else
        begin
            cnt_next = cnt_reg + ONE;
        end
        // Odd ratios leave the high phase one count short
        level_next = (cnt_next < (eff >> 1));
    end

    // Register count, level and edge pulses
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt_reg <= '0;
            level   <= 1'b0;
            rise    <= 1'b0;
            fall    <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            level   <= level_next;
            rise    <= level_next & ~level;
            fall    <= ~level_next & level;
        end
    end

endmodule

// *** cossd_top.sv ***
// Output shape, output enable and stop control of the clock generator
//
// Notes on behaviour
// RQ1: Top nibble all ones selects frame pulse.
// RQ2: Otherwise all 24 bits are divide ratio.
// RQ3: Software keeps plain ratio at or below maximum.
// RQ4: Differential enable bit n drives output n.
// RQ5: Single-ended enable low nibble; upper nibble reserved.
// RQ6: Divider C stop: run, park low, park high.
// RQ7: Divider D stop uses the same coding.
// RQ8: Low sixteen bits count related periods per frame.
// RQ9: Related clock A, B or C; pulse one period.
// RQ10: Bit 18 inverts frame pulse polarity.
// RQ11: Bit 19 picks mid-pulse or edge-marked boundary.
// RQ12: Stop and restart only at clean edges.
`timescale 1ns/1ps
module cossd_top #(
    parameter int S1A_RATIO = 4,           // Related clock A divide
    parameter int S1B_RATIO = 8,           // Related clock B divide
    parameter int S1C_RATIO = 16,          // Related clock C divide
    parameter int S0C_RATIO = 4,           // Synth 0 divider C divide
    parameter int S0D_RATIO = 6            // Synth 0 divider D divide
) (
    input  wire logic                          clk_sys,
    input  wire logic                          resetn,
    input  wire logic [cossd_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [cossd_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic      [cossd_pkg::DATA_W-1:0]  reg_rdata,
    output logic      [cossd_pkg::DIFF_N-1:0]  differential_output_enable,
    output logic      [cossd_pkg::SE_N-1:0]    single_ended_output_enable,
    output logic                               divider_c_output,
    output logic                               divider_d_output,
    output logic                               synth1_divider_d_output
);
    import cossd_pkg::*;

    // ****************************************************************
    // Configuration registers
    // ****************************************************************
    logic [RATIO_W-1:0] s1d_cfg_reg;       // Divider D shape and ratio
    logic [RATIO_W-1:0] s1d_cfg_next;
    logic [DATA_W-1:0]  diff_en_reg;       // Differential enables
    logic [DATA_W-1:0]  diff_en_next;
    logic [DATA_W-1:0]  se_en_reg;         // Single-ended enables
    logic [DATA_W-1:0]  se_en_next;
    logic [DATA_W-1:0]  stop_reg;          // Stop controls
    logic [DATA_W-1:0]  stop_next;
    logic [DATA_W-1:0]  rdata_next;

    // Byte writes land in place; reads answer the next cycle
    always_comb
    begin
        s1d_cfg_next = s1d_cfg_reg;
        diff_en_next = diff_en_reg;
        se_en_next   = se_en_reg;
        stop_next    = stop_reg;
        rdata_next   = reg_rdata;
        if (reg_wr)
        begin
            if (reg_addr == ADDR_S1D_HI)
                s1d_cfg_next[23:16] = reg_wdata;
            else if (reg_addr == ADDR_S1D_MID)
                s1d_cfg_next[15:8] = reg_wdata;
            else if (reg_addr == ADDR_S1D_LO)
                s1d_cfg_next[7:0] = reg_wdata;
            else if (reg_addr == ADDR_DIFF_EN)
                diff_en_next = reg_wdata;        // RQ4
            else if (reg_addr == ADDR_SE_EN)
                se_en_next = reg_wdata;          // RQ5
            else if (reg_addr == ADDR_STOP)
                stop_next = reg_wdata;
        end
        if (reg_rd)
        begin
            if (reg_addr == ADDR_S1D_HI)
                rdata_next = s1d_cfg_reg[23:16];
            else if (reg_addr == ADDR_S1D_MID)
                rdata_next = s1d_cfg_reg[15:8];
            else if (reg_addr == ADDR_S1D_LO)
                rdata_next = s1d_cfg_reg[7:0];
            else if (reg_addr == ADDR_DIFF_EN)
                rdata_next = diff_en_reg;
            else if (reg_addr == ADDR_SE_EN)
                rdata_next = se_en_reg;
            else if (reg_addr == ADDR_STOP)
                rdata_next = stop_reg;
            else
                rdata_next = RD_ZERO;            // Unmapped reads as zero
        end
    end

    // Register file flops
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            s1d_cfg_reg <= RST_S1D;
            diff_en_reg <= RST_DIFF_EN;
            se_en_reg   <= RST_SE_EN;
            stop_reg    <= RST_STOP;
            reg_rdata   <= RD_ZERO;
        end
        else
        begin
            s1d_cfg_reg <= s1d_cfg_next;
            diff_en_reg <= diff_en_next;
            se_en_reg   <= se_en_next;
            stop_reg    <= stop_next;
            reg_rdata   <= rdata_next;
        end
    end

    // Enables come straight from their flops; low level tristates
    assign differential_output_enable = diff_en_reg;           // RQ4
    assign single_ended_output_enable = se_en_reg[SE_N-1:0];   // RQ5

    // ****************************************************************
    // Dividers
    // ****************************************************************
    logic [4:0] dv_level;                  // A, B, C, s0 C, s0 D
    logic [4:0] dv_rise;
    logic [4:0] dv_fall;
    logic       d_level;                   // Synth 1 divider D plain clock
    logic [RATIO_W-1:0] fixed_ratio [5];

    assign fixed_ratio[0] = RATIO_W'(S1A_RATIO);
    assign fixed_ratio[1] = RATIO_W'(S1B_RATIO);
    assign fixed_ratio[2] = RATIO_W'(S1C_RATIO);
    assign fixed_ratio[3] = RATIO_W'(S0C_RATIO);
    assign fixed_ratio[4] = RATIO_W'(S0D_RATIO);

    // Fixed dividers standing for the neighbouring post-dividers
    for (genvar g = 0; g < 5; g++)
    begin : g_div
        cossd_divider #(.WIDTH(RATIO_W)) u_div (
            .clk_sys (clk_sys),
            .resetn  (resetn),
            .ratio   (fixed_ratio[g]),
            .level   (dv_level[g]),
            .rise    (dv_rise[g]),
            .fall    (dv_fall[g])
        );
    end

    // Whole 24-bit field is the ratio in plain mode
    cossd_divider #(.WIDTH(RATIO_W)) u_div_d (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ratio   (s1d_cfg_reg),                             // RQ2
        .level   (d_level),
        .rise    (),
        .fall    ()
    );

    // ****************************************************************
    // Frame pulse generator
    // ****************************************************************
    logic             frm_mode;            // Frame shape selected
    logic [1:0]       frm_sel;
    logic             rel_ok;              // Select names a real clock
    logic             rel_rise;            // Selected related clock edges
    logic             rel_fall;
    logic [PER_W-1:0] frm_last;            // Last count before boundary
    logic [PER_W-1:0] frm_cnt_reg;
    logic [PER_W-1:0] frm_cnt_next;
    logic             frm_act_reg;         // Pulse asserted, before polarity
    logic             frm_act_next;
    logic             d_out_next;

    assign frm_mode = (s1d_cfg_reg[MODE_HI:MODE_LO] == MODE_FRAME);  // RQ1
    assign frm_sel  = s1d_cfg_reg[SEL_HI:SEL_LO];

    // Related clock pick; the reserved code gives no edges at all
    always_comb
    begin
        rel_ok   = 1'b1;
        rel_rise = 1'b0;
        rel_fall = 1'b0;
        if (frm_sel == SEL_A)                                   // RQ9
        begin
            rel_rise = dv_rise[0];
            rel_fall = dv_fall[0];
        end
        else if (frm_sel == SEL_B)
        begin
            rel_rise = dv_rise[1];
            rel_fall = dv_fall[1];
        end
        else if (frm_sel == SEL_C)
        begin
            rel_rise = dv_rise[2];
            rel_fall = dv_fall[2];
        end
        else
        begin
            rel_ok = 1'b0;                 // Reserved code
        end
    end

    // Period counter and pulse state; a zero period acts as one
    always_comb
    begin
        frm_last = (s1d_cfg_reg[PER_W-1:0] == '0) ? '0
                 : s1d_cfg_reg[PER_W-1:0] - PER_W'(1);         // RQ8
        frm_cnt_next = frm_cnt_reg;
        frm_act_next = frm_act_reg;
        if (!frm_mode)
        begin
            frm_cnt_next = '0;
            frm_act_next = 1'b0;
        end
        else if (!rel_ok)
        begin
            // Without edges a live pulse would freeze, so drop it
            frm_cnt_next = '0;
            frm_act_next = 1'b0;                                // RQ9
        end
        else
        begin
            if (rel_rise)
                frm_cnt_next = (frm_cnt_reg >= frm_last) ? '0
                             : frm_cnt_reg + PER_W'(1);         // RQ8
            if (s1d_cfg_reg[TYPE_BIT])
            begin
                // Edge-marked: high from boundary rise to next rise
                if (rel_rise)
                    frm_act_next = (frm_cnt_reg >= frm_last);   // RQ11
            end
            else if (rel_fall)
            begin
                // Mid-pulse: half a period either side of boundary
                frm_act_next = (frm_cnt_reg >= frm_last);       // RQ11
            end
        end
        // Output mux; registered so the pin never sees a decode glitch
        d_out_next = frm_mode ? (frm_act_next ^ s1d_cfg_reg[POL_BIT]) // RQ10
                              : d_level;                        // RQ2
    end

    // Frame flops
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            frm_cnt_reg             <= '0;
            frm_act_reg             <= 1'b0;
            synth1_divider_d_output <= 1'b0;
        end
        else
        begin
            frm_cnt_reg             <= frm_cnt_next;
            frm_act_reg             <= frm_act_next;
            synth1_divider_d_output <= d_out_next;
        end
    end

    // ****************************************************************
    // Stop control for synth 0 dividers C and D
    // ****************************************************************
    cossd_halt_type    halt_reg  [HALT_N];
    cossd_halt_type    halt_next [HALT_N];
    logic [HALT_N-1:0] hout_reg;           // Gated clock levels
    logic [HALT_N-1:0] hout_next;
    logic [1:0]        hcode     [HALT_N];
    logic [HALT_N-1:0] park_hi_reg;        // Level at which output parked
    logic [HALT_N-1:0] park_hi_next;

    assign hcode[0] = stop_reg[STOP_C_LO+1:STOP_C_LO];          // RQ6
    assign hcode[1] = stop_reg[STOP_D_LO+1:STOP_D_LO];          // RQ7

    // Park only on the matching edge and leave only on the edge that
    // ends the parked level, so no runt reaches the pin
    always_comb
    begin
        for (int i = 0; i < HALT_N; i++)
        begin
            halt_next[i]    = halt_reg[i];
            hout_next[i]    = hout_reg[i];
            park_hi_next[i] = park_hi_reg[i];
            case (halt_reg[i])
                HALT_RUN:
                begin
                    hout_next[i] = dv_level[3+i];
                    if ((hcode[i] == STOP_LOW && dv_fall[3+i]) ||
                        (hcode[i] == STOP_HIGH && dv_rise[3+i]))  // RQ12
                    begin
                        halt_next[i]    = HALT_PARKED;
                        park_hi_next[i] = (hcode[i] == STOP_HIGH);
                    end
                end
                HALT_PARKED:
                begin
                    hout_next[i] = park_hi_reg[i];
                    if ((hcode[i] != STOP_LOW && hcode[i] != STOP_HIGH) &&
                        (park_hi_reg[i] ? dv_fall[3+i] : dv_rise[3+i]))
                    begin
                        halt_next[i] = HALT_RUN;                // RQ12
                        hout_next[i] = dv_level[3+i];
                    end
                end
                default:
                begin
                    halt_next[i] = HALT_RUN;
                end
            endcase
        end
    end

    // Stop flops
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int i = 0; i < HALT_N; i++)
                halt_reg[i] <= HALT_RUN;
            hout_reg    <= '0;
            park_hi_reg <= '0;
        end
        else
        begin
            for (int i = 0; i < HALT_N; i++)
                halt_reg[i] <= halt_next[i];
            hout_reg    <= hout_next;
            park_hi_reg <= park_hi_next;
        end
    end

    assign divider_c_output = hout_reg[0];
    assign divider_d_output = hout_reg[1];

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_plain_clock;
        @(posedge clk_sys) disable iff (!resetn)
        (!frm_mode && $past(!frm_mode)) |=>
            synth1_divider_d_output == $past(d_level);
    endproperty
    a_plain_clock: assert property (p_plain_clock) // RQ2
        else $error("plain mode output does not follow divider");

    property p_frame_mode;
        @(posedge clk_sys) disable iff (!resetn)
        !frm_mode |=> !frm_act_reg;
    endproperty
    a_frame_mode: assert property (p_frame_mode) // RQ1
        else $error("frame pulse active outside frame mode");

    property p_polarity;
        @(posedge clk_sys) disable iff (!resetn)
        (frm_mode && $stable(s1d_cfg_reg)) |->
            synth1_divider_d_output == (frm_act_reg ^ s1d_cfg_reg[POL_BIT]);
    endproperty
    a_polarity: assert property (p_polarity) // RQ10
        else $error("frame pulse polarity wrong");

    property p_period;
        @(posedge clk_sys) disable iff (!resetn)
        (frm_mode && $stable(s1d_cfg_reg)) |=> frm_cnt_reg <= frm_last;
    endproperty
    a_period: assert property (p_period) // RQ8
        else $error("frame period counter overran");

    property p_edge_type;
        @(posedge clk_sys) disable iff (!resetn)
        (frm_mode && s1d_cfg_reg[TYPE_BIT] && rel_rise &&
         frm_cnt_reg >= frm_last) |=> frm_act_reg && frm_cnt_reg == '0;
    endproperty
    a_edge_type: assert property (p_edge_type) // RQ11
        else $error("edge-marked pulse did not start at boundary");

    property p_reserved_sel;
        @(posedge clk_sys) disable iff (!resetn)
        (frm_mode && frm_sel == 2'h3) |=> !frm_act_reg;
    endproperty
    a_reserved_sel: assert property (p_reserved_sel) // RQ9
        else $error("reserved related clock made a pulse");

    property p_diff_en;
        @(posedge clk_sys) disable iff (!resetn)
        (reg_wr && reg_addr == ADDR_DIFF_EN) |=>
            differential_output_enable == $past(reg_wdata);
    endproperty
    a_diff_en: assert property (p_diff_en) // RQ4
        else $error("differential enable not written");

    property p_se_en;
        @(posedge clk_sys) disable iff (!resetn)
        (reg_wr && reg_addr == ADDR_SE_EN) |=>
            single_ended_output_enable == $past(reg_wdata[SE_N-1:0]);
    endproperty
    a_se_en: assert property (p_se_en) // RQ5
        else $error("single-ended enable not written");

    property p_park_c;
        @(posedge clk_sys) disable iff (!resetn)
        (halt_reg[0] == HALT_PARKED && hcode[0] == STOP_LOW) |=>
            !divider_c_output || $past(park_hi_reg[0]);
    endproperty
    a_park_c: assert property (p_park_c) // RQ6
        else $error("divider C did not hold low");

    property p_park_d;
        @(posedge clk_sys) disable iff (!resetn)
        (halt_reg[1] == HALT_RUN && hcode[1] == STOP_HIGH && dv_rise[4])
            |=> (halt_reg[1] == HALT_PARKED) [*2] ##0 divider_d_output;
    endproperty
    a_park_d: assert property (p_park_d) // RQ7
        else $error("divider D did not park high");

    property p_no_runt;
        @(posedge clk_sys) disable iff (!resetn)
        (halt_reg[0] == HALT_PARKED) ##1 (halt_reg[0] == HALT_RUN) |->
            $past(park_hi_reg[0] ? dv_fall[3] : dv_rise[3]);
    endproperty
    a_no_runt: assert property (p_no_runt) // RQ12
        else $error("divider C restarted off its edge");

endmodule

// *** tb_top.sv ***
// Self-checking testbench for the clock output shape, enable and stop block
`timescale 1ns/1ps
module tb_top;
    import cossd_pkg::*;
    // ****************************************************************
    // Stimulus, observed outputs and tallies
    // ****************************************************************
    logic              clk_sys   = 1'b0;   // 200 MHz system clock
    logic              resetn    = 1'b0;   // Held low at start
    logic [ADDR_W-1:0] reg_addr  = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic              reg_wr    = 1'b0;
    logic              reg_rd    = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [DIFF_N-1:0] diff_en;           // Differential enables seen
    logic [SE_N-1:0]   se_en;             // Single-ended enables seen
    logic              c_out;
    logic              d_out;
    logic              s1d_out;
    logic [7:0]        b;                 // Scratch read byte
    logic [7:0]        h;                 // Scratch high count
    int                err_count  = 0;
    int                n_compared = 0;
    // Frame codes: regular, inverted, edge type, clock B, reserved select
    logic [7:0] fcode [5] = '{8'hF0, 8'hF4, 8'hF8, 8'hF1, 8'hF3};
    logic [7:0] fhigh [5] = '{8'h10, 8'h30, 8'h10, 8'h10, 8'h00};
    // Stop codes and high counts over 24 cycles for C and D
    logic [7:0] scode [4] = '{8'h0E, 8'h05, 8'h0B, 8'h00};
    logic [7:0] chigh [4] = '{8'h00, 8'h0C, 8'h18, 8'h0C};
    logic [7:0] dhigh [4] = '{8'h18, 8'h0C, 8'h00, 8'h0C};

    always #2.5 clk_sys = ~clk_sys;

    cossd_top cossd_top_inst (
        .clk_sys                    (clk_sys),
        .resetn                     (resetn),
        .reg_addr                   (reg_addr),
        .reg_wdata                  (reg_wdata),
        .reg_wr                     (reg_wr),
        .reg_rd                     (reg_rd),
        .reg_rdata                  (reg_rdata),
        .differential_output_enable (diff_en),
        .single_ended_output_enable (se_en),
        .divider_c_output           (c_out),
        .divider_d_output           (d_out),
        .synth1_divider_d_output    (s1d_out)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [7:0] exp,
                       input logic [7:0] got);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One write pulse; strobe drops at the taking edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // Read data lands at the taking edge; sampled half a cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask

    // Count high samples; windows span whole periods so phase is moot
    task automatic highs(input int which, input int n, output logic [7:0] c);
        logic v;
        c = 8'h00;
        repeat (n)
        begin
            @(negedge clk_sys);
            v = (which == 0) ? c_out : (which == 1) ? d_out : s1d_out;
            if (v === 1'b1)
                c++;
        end
    endtask

    task automatic end_of_test();
        if (err_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        rd(ADDR_S1D_HI, b);  chk("s1d_hi", RST_S1D[23:16], b);
        rd(ADDR_S1D_MID, b); chk("s1d_mid", RST_S1D[15:8], b);
        rd(ADDR_S1D_LO, b);  chk("s1d_lo", RST_S1D[7:0], b);
        rd(ADDR_DIFF_EN, b); chk("diff_rd", RST_DIFF_EN, b);
        rd(ADDR_SE_EN, b);   chk("se_rd", RST_SE_EN, b);
        rd(ADDR_STOP, b);    chk("stop_rd", RST_STOP, b);
        rd(8'h50, b);        chk("unmapped", RD_ZERO, b);
    endtask

    // Each enable bit maps to its own output; writes leave the reserved nibble zero
    task automatic t_enable();
        wr(ADDR_DIFF_EN, 8'hA5);
        wr(ADDR_DIFF_EN, 8'h5A);
        @(negedge clk_sys);
        chk("diff_en", 8'h5A, diff_en);
        wr(ADDR_SE_EN, 8'h05);
        wr(ADDR_SE_EN, 8'h0A);
        @(negedge clk_sys);
        chk("se_en", 8'h0A, {4'h0, se_en});
        rd(ADDR_SE_EN, b);
        chk("se_rd", 8'h0A, b);
    endtask

    // Even and odd plain ratios: 3 high per 6, 3 high per 7
    task automatic t_plain();
        wr(ADDR_S1D_LO, 8'h06);
        repeat (20) @(posedge clk_sys);
        highs(2, 60, h);
        chk("ratio6", 8'h1E, h);
        wr(ADDR_S1D_LO, 8'h07);
        repeat (20) @(posedge clk_sys);
        highs(2, 70, h);
        chk("ratio7", 8'h1E, h);
    endtask

    // Low bytes first, top byte last, so no transient mode appears
    task automatic t_frame();
        wr(ADDR_S1D_LO, 8'h04);
        wr(ADDR_S1D_MID, 8'h00);
        for (int i = 0; i < 5; i++)
        begin
            wr(ADDR_S1D_HI, fcode[i]);
            repeat (40) @(posedge clk_sys);
            highs(2, 64, h);
            chk("frame", fhigh[i], h);
        end
        wr(ADDR_S1D_HI, 8'h00);
    endtask

    // Park C low and D high, run on code 01, park C high and D low, run again
    task automatic t_stop();
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_STOP, scode[i]);
            repeat (30) @(posedge clk_sys);
            highs(0, 24, h);
            chk("stop_c", chigh[i], h);
            highs(1, 24, h);
            chk("stop_d", dhigh[i], h);
        end
    endtask

    initial
    begin
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        t_reset();
        t_enable();
        t_plain();
        t_frame();
        t_stop();
        end_of_test();
    end

    // Hang guard: counts as a mismatch
    initial
    begin
        #200000;
        err_count++;
        end_of_test();
    end
endmodule
